// file: smbus_status_pkg.sv
// Constants for the serial bus status block: register offsets, field
// positions, reset values and counts.
// Assumes a 32-bit APB slave on a single 125 MHz clock.
//
// Functional notes
// (RL1) Slave port address readable at bits 7:1.
// (RL2) Master port address readable at bits 15:9.
// (RL3) Bit 24 sets when boot initialization ends.
// (RL4) Bit 25 sets on unexpected master NACK.
// (RL5) Lost arbitration retries automatically.
// (RL6) Sixteen straight losses abort, set bit 26.
// (RL7) Bit 27 sets on misplaced START/STOP.
// (RL8) Bit 28 sets on bad init checksum.
// (RL9) Missing config-done command also sets bit 28.
// (RL10) Bit 29 sets on unmapped init write.
// (RL11) Error flags reset zero, write-one clears.
// (RL12) Reserved status bits read as zero.
// (RL13) Checksum-ignore control masks checksum errors.
// (RL14) Ignore-competitors control continues after lost arbitration.
// (RL15) Hardware set beats same-cycle software clear.
package smbus_status_pkg;

    // --------------------
    // Register byte offsets
    // --------------------
    localparam logic [11:0] serial_bus_status_off = 12'h344;  // Status register.
    localparam logic [11:0] serial_bus_control_off = 12'h348; // Control register.
    localparam logic [11:0] irq_mask_off          = 12'h350;  // Interrupt mask.
    localparam logic [11:0] irq_status_off        = 12'h354;  // Interrupt status, clear on read.

    // --------------------
    // Field positions
    // --------------------
    localparam int slave_addr_lsb      = 1;   // Slave port address low bit.
    localparam int master_addr_lsb     = 9;   // Master port address low bit.
    localparam int init_done_bit       = 24;  // Boot init complete.
    localparam int nack_bit            = 25;  // First error flag.
    localparam int err_count           = 5;   // Number of error flags.
    localparam int ignore_comp_bit     = 16;  // Master ignores competitors.
    localparam int checksum_ignore_bit = 17;  // Checksum always passes.

    // --------------------
    // Event indexes and counts
    // --------------------
    localparam int ev_nack     = 0;  // Unexpected NACK.
    localparam int ev_arb      = 1;  // Arbitration retries exhausted.
    localparam int ev_misplace = 2;  // Misplaced START or STOP.
    localparam int ev_checksum = 3;  // Checksum or missing done command.
    localparam int ev_unmapped = 4;  // Unmapped init write.
    localparam int ev_done     = 5;  // Init done, interrupt only.
    localparam int irq_width   = 6;  // Interrupt status width.
    localparam logic [4:0] arb_loss_limit = 5'h10;  // Sixteen losses.
    localparam logic [31:0] reg_reset     = 32'h0000_0000;  // Reset value.

    // Arbitration engine states.
    typedef enum logic [1:0] {arb_idle, arb_try, arb_run} arb_state_type;

endpackage : smbus_status_pkg

// file: smbus_status_flags.sv
// Top of the serial bus status block: APB registers, error flags,
// arbitration retry tracking and interrupt.
// Assumes event inputs are single-cycle pulses synchronous to clk_in.
//
// Design decision made here: the APB interface to the registers.
module smbus_status_flags (
    // Clock and reset.
    input  wire  logic        clk_in,
    input  wire  logic        resetn_in,
    // APB slave.
    input  wire  logic        psel_in,
    input  wire  logic        penable_in,
    input  wire  logic        pwrite_in,
    input  wire  logic [11:0] paddr_in,
    input  wire  logic [31:0] pwdata_in,
    output logic              pready_out,
    output logic              pslverr_out,
    output logic [31:0]       prdata_out,
    // Hardware initialization values; addresses sampled after reset, boot mode read live.
    input  wire  logic [6:0]  slave_port_address_in,
    input  wire  logic [6:0]  master_port_address_in,
    input  wire  logic        boot_init_mode_in,
    // Boot initialization events.
    input  wire  logic        init_finish_in,
    input  wire  logic        init_checksum_bad_in,
    input  wire  logic        init_no_done_cmd_in,
    input  wire  logic        init_unmapped_write_in,
    // Master port events.
    input  wire  logic        master_start_in,
    input  wire  logic        master_arb_won_in,
    input  wire  logic        master_arb_lost_in,
    input  wire  logic        master_nack_in,
    input  wire  logic        master_misplaced_in,
    input  wire  logic        master_xfer_end_in,
    // Master port control.
    output logic              master_arb_request_out,
    output logic              master_proceed_out,
    output logic              master_abort_out,
    // Control levels and interrupt.
    output logic              master_ignore_competitors_out,
    output logic              irq_out
);

    // --------------------
    // Declarations
    // --------------------
    logic [6:0]  slave_addr_q;       // Latched slave address.
    logic [6:0]  master_addr_q;      // Latched master address.
    logic        straps_taken_q;     // Straps captured after release.
    logic        init_done_q;        // Boot init complete flag.
    logic [4:0]  err_q;              // Sticky error flags.
    logic [4:0]  err_set;            // Hardware set pulses.
    logic [31:0] ctrl_q;             // Control register.
    logic [5:0]  irq_mask_q;         // Interrupt mask.
    logic [5:0]  irq_stat_q;         // Interrupt sticky status.
    logic [5:0]  irq_ev;             // Interrupt event pulses.
    logic        arb_exhausted;      // Retry limit reached pulse.
    logic        wr_en;              // APB write access.
    logic        rd_en;              // APB read access.
    logic        checksum_ignore;    // Checksum errors masked.
    logic [31:0] status_word;        // Assembled status.

    // Returns true when an access targets the given offset.
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction : hit

    assign wr_en = psel_in & penable_in & pwrite_in;
    assign rd_en = psel_in & penable_in & ~pwrite_in;
    assign checksum_ignore = ctrl_q[smbus_status_pkg::checksum_ignore_bit];

    // --------------------
    // Hardware initialization capture
    // --------------------

    // Straps are caught by the clock once reset has been released.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slave_addr_q   <= 7'h00;
            master_addr_q  <= 7'h00;
            straps_taken_q <= 1'b0;
        end else if (!straps_taken_q) begin
            // (RL1) Capture slave address.
            slave_addr_q   <= slave_port_address_in;
            // (RL2) Capture master address.
            master_addr_q  <= master_port_address_in;
            straps_taken_q <= 1'b1;
        end
    end

    // --------------------
    // Boot initialization done
    // --------------------

    // Sets once when init finishes or fails, only in boot init mode.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            init_done_q <= 1'b0;
        end else if (boot_init_mode_in) begin
            // (RL3) Done on finish or error.
            if (init_finish_in | init_unmapped_write_in | err_set[smbus_status_pkg::ev_checksum]) begin
                init_done_q <= 1'b1;
            end
        end
    end

    // --------------------
    // Arbitration retry engine
    // --------------------
    smbus_arb_retry u_arb (
        .clk_in                 (clk_in),
        .resetn_in              (resetn_in),
        .start_in               (master_start_in),
        .won_in                 (master_arb_won_in),
        .lost_in                (master_arb_lost_in),
        .end_in                 (master_xfer_end_in),
        .ignore_competitors_in  (master_ignore_competitors_out),
        .request_out            (master_arb_request_out),
        .proceed_out            (master_proceed_out),
        .abort_out              (master_abort_out),
        .exhausted_out          (arb_exhausted)
    );

    // --------------------
    // Error flag set sources
    // --------------------
    always_comb begin
        // (RL4) NACK seen.
        err_set[smbus_status_pkg::ev_nack]     = master_nack_in;
        // (RL6) Retries exhausted.
        err_set[smbus_status_pkg::ev_arb]      = arb_exhausted;
        // (RL7) Misplaced condition.
        err_set[smbus_status_pkg::ev_misplace] = master_misplaced_in;
        // (RL8) (RL9) (RL13) Checksum unless ignored, or missing done.
        err_set[smbus_status_pkg::ev_checksum] = (init_checksum_bad_in & ~checksum_ignore) | init_no_done_cmd_in;
        // (RL10) Unmapped init write.
        err_set[smbus_status_pkg::ev_unmapped] = init_unmapped_write_in;
    end

    // --------------------
    // Sticky error flags
    // --------------------
    genvar gi;
    generate
        for (gi = 0; gi < smbus_status_pkg::err_count; gi++) begin : g_err
            // Each flag sets from hardware and clears on a written one.
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    // (RL11) Reset to zero.
                    err_q[gi] <= 1'b0;
                end else if (err_set[gi]) begin
                    // (RL15) Set wins clear.
                    err_q[gi] <= 1'b1;
                end else if (wr_en && hit(paddr_in, smbus_status_pkg::serial_bus_status_off)
                             && pwdata_in[smbus_status_pkg::nack_bit + gi]) begin
                    // (RL11) Write one clears.
                    err_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // --------------------
    // Control and mask registers
    // --------------------

    // Control register holds the checksum-ignore and competitor bits.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q     <= smbus_status_pkg::reg_reset;
            irq_mask_q <= 6'h00;
        end else if (wr_en) begin
            if (hit(paddr_in, smbus_status_pkg::serial_bus_control_off)) begin
                ctrl_q <= pwdata_in;
            end
            if (hit(paddr_in, smbus_status_pkg::irq_mask_off)) begin
                irq_mask_q <= pwdata_in[5:0];
            end
        end
    end

    // Competitor-ignore level, registered for the port engine.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            master_ignore_competitors_out <= 1'b0;
        end else begin
            master_ignore_competitors_out <= ctrl_q[smbus_status_pkg::ignore_comp_bit];
        end
    end

    // --------------------
    // Interrupt status and output
    // --------------------
    assign irq_ev = {init_done_q == 1'b0 && boot_init_mode_in
                     && (init_finish_in | init_unmapped_write_in | err_set[smbus_status_pkg::ev_checksum]),
                     err_set};

    // Sticky events, cleared by a read; a new event wins over the read.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat_q <= 6'h00;
        end else if (rd_en && hit(paddr_in, smbus_status_pkg::irq_status_off)) begin
            irq_stat_q <= irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    // Level interrupt while any unmasked status bit is set.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((irq_stat_q | irq_ev) & irq_mask_q);
        end
    end

    // --------------------
    // Read data and APB answer
    // --------------------
    always_comb begin
        // (RL12) Reserved bits are zero.
        status_word = 32'h0000_0000;
        status_word[smbus_status_pkg::slave_addr_lsb +: 7]  = slave_addr_q;
        status_word[smbus_status_pkg::master_addr_lsb +: 7] = master_addr_q;
        status_word[smbus_status_pkg::init_done_bit]        = init_done_q;
        status_word[smbus_status_pkg::nack_bit +: 5]        = err_q;
    end

    // Zero-wait answer: pready in the access phase, registered.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            if (psel_in && !penable_in) begin
                case (paddr_in)
                    smbus_status_pkg::serial_bus_status_off:  prdata_out <= status_word;
                    smbus_status_pkg::serial_bus_control_off: prdata_out <= ctrl_q;
                    smbus_status_pkg::irq_mask_off:           prdata_out <= {26'h0, irq_mask_q};
                    smbus_status_pkg::irq_status_off:         prdata_out <= {26'h0, irq_stat_q | irq_ev};
                    // Unmapped address answers with an error.
                    default:                                  pslverr_out <= 1'b1;
                endcase
                // Writes return no data.
                if (pwrite_in) begin
                    prdata_out <= 32'h0000_0000;
                end
            end
        end
    end

endmodule : smbus_status_flags

// file: smbus_arb_retry.sv
// Arbitration retry engine of the master port.
// Assumes won, lost, start and end are single-cycle pulses on clk_in.
module smbus_arb_retry (
    // Clock and reset.
    input  wire  logic clk_in,
    input  wire  logic resetn_in,
    // Port events.
    input  wire  logic start_in,
    input  wire  logic won_in,
    input  wire  logic lost_in,
    input  wire  logic end_in,
    input  wire  logic ignore_competitors_in,
    // Port control.
    output logic       request_out,
    output logic       proceed_out,
    output logic       abort_out,
    output logic       exhausted_out
);

    // --------------------
    // State
    // --------------------
    smbus_status_pkg::arb_state_type state_q;  // Engine state.
    logic [4:0]                      losses_q; // Consecutive losses.

    // Requests arbitration, retries on loss, aborts at the limit.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q       <= smbus_status_pkg::arb_idle;
            losses_q      <= 5'h00;
            request_out   <= 1'b0;
            proceed_out   <= 1'b0;
            abort_out     <= 1'b0;
            exhausted_out <= 1'b0;
        end else begin
            abort_out     <= 1'b0;
            exhausted_out <= 1'b0;
            case (state_q)
                smbus_status_pkg::arb_idle: begin
                    if (start_in) begin
                        state_q     <= smbus_status_pkg::arb_try;
                        losses_q    <= 5'h00;
                        request_out <= 1'b1;
                    end
                end
                smbus_status_pkg::arb_try: begin
                    if (won_in || (lost_in && ignore_competitors_in)) begin
                        // (RL14) Proceed even when lost.
                        state_q     <= smbus_status_pkg::arb_run;
                        request_out <= 1'b0;
                        proceed_out <= 1'b1;
                    end else if (lost_in) begin
                        if (losses_q + 5'h01 == smbus_status_pkg::arb_loss_limit) begin
                            // (RL6) Abort after sixteen.
                            state_q       <= smbus_status_pkg::arb_idle;
                            request_out   <= 1'b0;
                            abort_out     <= 1'b1;
                            exhausted_out <= 1'b1;
                        end else begin
                            // (RL5) Retry automatically.
                            losses_q <= losses_q + 5'h01;
                        end
                    end
                end
                smbus_status_pkg::arb_run: begin
                    if (end_in) begin
                        state_q     <= smbus_status_pkg::arb_idle;
                        proceed_out <= 1'b0;
                    end
                end
                default: begin
                    state_q <= smbus_status_pkg::arb_idle;
                end
            endcase
        end
    end

endmodule : smbus_arb_retry

// file: smbus_far_side.sv
// Behavioural model of the far side of the master port: competing masters
// and the addressed target. Answers each arbitration with lost or won.
// Assumes the master port's request and proceed levels are registered.
module smbus_far_side (
    // Clock and reset.
    input  wire  logic       clk_in,
    input  wire  logic       resetn_in,
    // Master port levels.
    input  wire  logic       request_in,
    input  wire  logic       proceed_in,
    // Scenario controls: losses before a win, idle cycles per answer.
    input  wire  logic [4:0] losses_in,
    input  wire  logic [1:0] gap_in,
    // Answers as single-cycle pulses.
    output logic             won_out,
    output logic             lost_out,
    output logic             end_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] lost_q;  // Losses handed out in this arbitration.
    logic [2:0] wait_q;  // Cycles left before the next answer.
    // The wait lets the master's state settle before we answer again.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {won_out, lost_out, end_out} <= 3'h0;
            lost_q <= 5'h00;
            wait_q <= 3'h0;
        end else begin
            {won_out, lost_out, end_out} <= 3'h0;
            if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (request_in && !proceed_in) begin
                wait_q <= {1'b0, gap_in} + 3'h1;
                if (lost_q < losses_in) begin
                    lost_out <= 1'b1;
                    lost_q   <= lost_q + 5'h01;
                end else begin
                    won_out <= 1'b1;
                end
            end else if (proceed_in) begin
                end_out <= 1'b1;
                wait_q  <= 3'h3;
                lost_q  <= 5'h00;
            end else begin
                lost_q <= 5'h00;
            end
        end
    end
endmodule : smbus_far_side

// file: smbus_status_flags_asserts.sv
// Port-level checks of the status block, bound to its top module.
// Assumes straps are steady and events are single-cycle pulses.
module smbus_status_flags_asserts (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic        pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic [6:0]  slave_port_address_in,
    input wire logic [6:0]  master_port_address_in,
    input wire logic        master_start_in,
    input wire logic        master_arb_won_in,
    input wire logic        master_arb_lost_in,
    input wire logic        master_arb_request_out,
    input wire logic        master_proceed_out,
    input wire logic        master_abort_out,
    input wire logic        master_ignore_competitors_out,
    input wire logic        irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic [4:0] loss_q;  // Consecutive losses in this arbitration.
    logic       rd_sts;  // Status register read completes now.
    logic       lose;    // A counted loss without the ignore control.
    assign rd_sts = psel_in && penable_in && pready_out && !pwrite_in
                    && paddr_in == smbus_status_pkg::serial_bus_status_off;
    assign lose = master_arb_lost_in && master_arb_request_out && !master_ignore_competitors_out;
    // Loss counter restarts with every new transaction.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            loss_q <= 5'h00;
        end else if (master_start_in && !master_arb_request_out) begin
            loss_q <= 5'h00;
        end else if (lose) begin
            loss_q <= loss_q + 5'h01;
        end
    end
    property p_abort_count; master_abort_out |-> loss_q == 5'h10; endproperty
    property p_retry; lose && loss_q < 5'h0F |=> master_arb_request_out && !master_abort_out; endproperty
    property p_limit; lose && loss_q == 5'h0F |=> master_abort_out && !master_arb_request_out; endproperty
    property p_ignore;
        master_arb_lost_in && master_arb_request_out && master_ignore_competitors_out |=> master_proceed_out;
    endproperty
    property p_won; master_arb_won_in && master_arb_request_out |=> master_proceed_out && !master_abort_out; endproperty
    property p_reserved; rd_sts |-> (prdata_out & 32'hC0FF_0101) == 32'h0000_0000; endproperty
    property p_slave; rd_sts |-> prdata_out[7:1] == slave_port_address_in; endproperty
    property p_master; rd_sts |-> prdata_out[15:9] == master_port_address_in; endproperty
    a_abort_count: assert property (p_abort_count) else $error("abort without sixteen losses");
    a_retry: assert property (p_retry) else $error("loss did not retry");
    a_limit: assert property (p_limit) else $error("sixteenth loss did not abort");
    a_ignore: assert property (p_ignore) else $error("loss not ignored");
    a_won: assert property (p_won) else $error("win did not proceed");
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
    a_slave: assert property (p_slave) else $error("slave address wrong");
    a_master: assert property (p_master) else $error("master address wrong");
    c_abort: cover property (master_abort_out);
    c_ignore: cover property (master_arb_lost_in && master_ignore_competitors_out);
    c_irq: cover property (irq_out);
endmodule : smbus_status_flags_asserts
bind smbus_status_flags smbus_status_flags_asserts chk_u (.*);

// file: smbus_status_flags_test.sv
// Self-checking bench: APB master, event pulses, far-side model.
// Assumes the design answers APB with pready and events are pulses.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module smbus_status_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] sts = 12'h344, ctl = 12'h348, msk = 12'h350, irs = 12'h354;
    localparam logic [32:0] all = 33'h1_FFFF_FFFF;
    logic        clk_in = 1'b0, resetn_in = 1'b0, boot = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic [6:0]  sa = 7'h00, ma = 7'h00, ev = 7'h00;  // Straps and event pulses.
    logic        pready_out, pslverr_out, won, lost, xend, req, proc, abrt, ign, irq;
    logic [4:0]  losses = 5'h00;
    logic [1:0]  gap = 2'h0;
    logic [32:0] exp_q[$], msk_q[$];  // Expected {pslverr, prdata} and care mask.
    int miscompares = 0, samples_checked = 0;
    int evt[5] = '{5, 6, 1, 2, 3};       // Nack, misplaced, checksum, no done, unmapped.
    int fb[5] = '{25, 27, 28, 28, 29};
    smbus_status_flags dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
        .slave_port_address_in(sa), .master_port_address_in(ma), .boot_init_mode_in(boot),
        .init_finish_in(ev[0]), .init_checksum_bad_in(ev[1]), .init_no_done_cmd_in(ev[2]),
        .init_unmapped_write_in(ev[3]), .master_start_in(ev[4]), .master_arb_won_in(won),
        .master_arb_lost_in(lost), .master_nack_in(ev[5]), .master_misplaced_in(ev[6]),
        .master_xfer_end_in(xend), .master_arb_request_out(req), .master_proceed_out(proc),
        .master_abort_out(abrt), .master_ignore_competitors_out(ign), .irq_out(irq));
    smbus_far_side far_u (.clk_in(clk_in), .resetn_in(resetn_in), .request_in(req),
        .proceed_in(proc), .losses_in(losses), .gap_in(gap), .won_out(won), .lost_out(lost),
        .end_out(xend));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // Takes the oldest expectation off the queue at each completed transfer.
    always @(posedge clk_in) begin
        if (psel_in && penable_in && pready_out === 1'b1) begin
            `CHK({pslverr_out, prdata_out} & msk_q[0], exp_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // One APB transfer; notes its expected answer first.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [32:0] e, input logic [32:0] m);
        int n;
        n = 0;
        exp_q.push_back(e);
        msk_q.push_back(m);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 64);
        if (n >= 64) miscompares++;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0, 33'h0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        xfer(1'b0, a, 32'h0, e, m);
    endtask : rd
    // Pulses one event line for a single cycle.
    task automatic fire(input int b);
        ev <= 7'h01 << b;
        @(posedge clk_in);
        ev <= 7'h00;
        @(posedge clk_in);
    endtask : fire
    task automatic results;
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        results();
    end
    initial begin
        int n;
        logic seen;
        void'($urandom(32'h2C3D));
        sa = 7'($urandom);
        ma = 7'($urandom);
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd(sts, {17'h0, ma, 1'b0, sa, 1'b0}, all);
        rd(ctl, 33'h0, all);
        rd(irs, 33'h0, all);
        rd(12'h34C, {1'b1, 32'h0}, all);
        xfer(1'b1, 12'h34C, 32'hFFFF_FFFF, {1'b1, 32'h0}, {1'b1, 32'h0});
        rd(sts, {17'h0, ma, 1'b0, sa, 1'b0}, all);
        boot <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            fire(evt[k]);
            rd(sts, 33'h1 << fb[k], 33'h1 << fb[k]);
            wr(sts, ~(32'h1 << fb[k]));
            rd(sts, 33'h1 << fb[k], 33'h1 << fb[k]);
            wr(sts, 32'h1 << fb[k]);
            rd(sts, 33'h0, 33'h0_3E00_0000);
        end
        fire(0);
        rd(sts, 33'h0_0100_0000, 33'h0_0100_0000);
        fork
            wr(sts, 32'h0200_0000);
            begin
                @(posedge clk_in);
                fire(5);
            end
        join
        rd(sts, 33'h0_0200_0000, 33'h0_0200_0000);
        wr(sts, 32'h3E00_0000);
        wr(ctl, 32'h0002_0000);
        rd(ctl, 33'h0_0002_0000, all);
        fire(1);
        rd(sts, 33'h0, 33'h0_1000_0000);
        for (int i = 0; i < 3; i++) begin
            losses <= (i == 0) ? 5'h03 : (i == 1) ? 5'h10 : 5'h14;
            gap <= 2'($urandom);
            wr(ctl, (i == 2) ? 32'h0001_0000 : 32'h0);
            @(negedge clk_in);
            `CHK(ign, i == 2)
            fire(4);
            n = 0;
            seen = 1'b0;
            do begin
                @(posedge clk_in);
                seen = seen | abrt;
                n++;
            end while ((req || proc) && n < 300);
            if (n >= 300) miscompares++;
            `CHK(seen, i == 1)
            rd(sts, (i == 1) ? 33'h0_0400_0000 : 33'h0, 33'h0_0400_0000);
            wr(sts, 32'h0400_0000);
        end
        wr(ctl, 32'h0);
        rd(irs, 33'h0, 33'h0);
        wr(msk, 32'h1);
        fire(5);
        @(negedge clk_in);
        `CHK(irq, 1'b1)
        rd(irs, 33'h1, 33'h3F);
        @(negedge clk_in);
        `CHK(irq, 1'b0)
        fire(6);
        @(negedge clk_in);
        `CHK(irq, 1'b0)
        rd(irs, 33'h4, 33'h3F);
        results();
    end
endmodule : smbus_status_flags_test
